//--- pbs_supervisor.sv
// power-on reset and supply drop supervisor sequencing
// assumes comparator levels arrive synchronous to mclk and the
// reset pin wire is resolved outside from rst_pin_oe
`timescale 1ns/1ns
module pbs_supervisor
  import pbs_pkg::*;
#(
  parameter int RC_DIV = RC_DIV_CYCLES,
  parameter int PWRUP_TICKS = PWRUP_RC_TICKS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // analog comparator levels
  input wire pbs_sup_t sup,
  // open-drain reset pin
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  // software side
  input wire logic thr_wr,
  input wire pbs_thr_t thr_wdata,
  input wire logic clr_core_int,
  input wire logic clr_io_int,
  input wire logic core_int_en,
  input wire logic io_int_en,
  // thresholds to the comparators
  output pbs_thr_t thr,
  // core control
  output logic cpu_reset,
  output logic cpu_start,
  output logic [15:0] reset_vector,
  output logic por_load,
  output logic bor_load,
  // supply drop interrupts
  output logic core_int_flag,
  output logic io_int_flag,
  output logic supply_drop_interrupt_core,
  output logic supply_drop_interrupt_io
);

  // ------------------------------------------------------------------
  // next-state decode
  // ------------------------------------------------------------------
  pbs_state_t state;
  pbs_state_t next_state;
  logic pwrup_done;
  logic pwrup_run;
  logic below_por;
  logic next_hold;
  logic next_por_load;
  logic next_bor_load;
  logic next_cpu_reset;
  logic wr_ok;
  logic core_set;
  logic io_set;
  logic next_core_flag;
  logic next_io_flag;
  pbs_thr_t next_thr;

  // loss of the power-on level overrides everything
  assign below_por = !sup.above_por;

  always_comb begin
    next_state = state;
    if (below_por) begin
      next_state = sup.above_hold ? S_POR_HOLD : S_DEAD;
    end else begin
      case (state)
        S_DEAD, S_POR_HOLD: begin
          next_state = S_WAIT_BOR;
        end
        S_WAIT_BOR: begin
          if (sup.above_reset) begin
            next_state = S_PWRUP;
          end
        end
        S_PWRUP: begin
          if (!sup.above_reset) begin
            next_state = S_WAIT_BOR;
          end else if (pwrup_done) begin
            next_state = S_RUN;
          end
        end
        S_RUN: begin
          if (!sup.above_reset) begin
            next_state = S_BOR;
          end
        end
        S_BOR: begin
          // no power-up delay on a drop recovery
          if (sup.above_reset) begin
            next_state = S_RUN;
          end
        end
        default: begin
          next_state = S_DEAD;
        end
      endcase
    end
  end

  // pin held low in every live state short of running
  assign next_hold = (next_state != S_RUN) && (next_state != S_DEAD);
  // external low on the pin also resets the core
  assign next_cpu_reset = (next_state != S_RUN) || !rst_pin_in;
  // defaults loaded on the crossing
  assign next_por_load = (next_state == S_WAIT_BOR) &&
                         ((state == S_DEAD) || (state == S_POR_HOLD));
  // drop defaults only on the way out of running
  assign next_bor_load = (next_state == S_BOR) && (state == S_RUN);

  // ------------------------------------------------------------------
  // thresholds: software writes only while the core runs
  // ------------------------------------------------------------------
  assign wr_ok = thr_wr && (state == S_RUN) && (next_state == S_RUN) &&
                 !cpu_reset;

  always_comb begin
    next_thr = thr;
    if (below_por || next_por_load) begin
      next_thr.io_supply_int_threshold = THR_POR_DEFAULT;
      next_thr.core_supply_int_threshold = THR_POR_DEFAULT;
      next_thr.core_supply_reset_threshold = THR_POR_DEFAULT;
    end else if (next_bor_load) begin
      // reset threshold kept so recovery keeps its margin
      next_thr.io_supply_int_threshold = THR_BOR_DEFAULT;
      next_thr.core_supply_int_threshold = THR_BOR_DEFAULT;
    end else if (wr_ok) begin
      next_thr = thr_wdata;
    end
  end

  // ------------------------------------------------------------------
  // supply drop flags; a set in the clear cycle wins
  // ------------------------------------------------------------------
  assign core_set = (state == S_RUN) && !sup.core_above_int;
  assign io_set = (state == S_RUN) && !sup.io_above_int;
  assign next_core_flag = (next_state != S_RUN) ? 1'b0 :
                          (core_set || (core_int_flag && !clr_core_int));
  assign next_io_flag = (next_state != S_RUN) ? 1'b0 :
                        (io_set || (io_int_flag && !clr_io_int));

  // ------------------------------------------------------------------
  // power-up counter
  // ------------------------------------------------------------------
  // leaving the count state restarts the delay from zero
  assign pwrup_run = (state == S_PWRUP);

  pbs_pwrup_timer #(
    .RC_DIV(RC_DIV),
    .TICKS(PWRUP_TICKS)
  ) u_timer (
    .mclk(mclk),
    .rst(rst),
    .run(pwrup_run),
    .done(pwrup_done)
  );

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // state and pin drive
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= S_DEAD;
      rst_pin_oe <= 1'b0;
      rst_pin_out <= 1'b0;
    end else begin
      state <= next_state;
      rst_pin_oe <= next_hold;
      rst_pin_out <= 1'b0; // open drain only ever pulls low
    end
  end

  // core reset and start pulse at release
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cpu_reset <= 1'b1;
      cpu_start <= 1'b0;
      reset_vector <= RESET_VECTOR;
      por_load <= 1'b0;
      bor_load <= 1'b0;
    end else begin
      cpu_reset <= next_cpu_reset;
      cpu_start <= cpu_reset && !next_cpu_reset;
      reset_vector <= RESET_VECTOR;
      por_load <= next_por_load;
      bor_load <= next_bor_load;
    end
  end

  // thresholds and flags
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      thr <= '0;
      core_int_flag <= 1'b0;
      io_int_flag <= 1'b0;
    end else begin
      thr <= next_thr;
      core_int_flag <= next_core_flag;
      io_int_flag <= next_io_flag;
    end
  end

  // interrupt requests gated by the enables
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      supply_drop_interrupt_core <= 1'b0;
      supply_drop_interrupt_io <= 1'b0;
    end else begin
      supply_drop_interrupt_core <= next_core_flag && core_int_en;
      supply_drop_interrupt_io <= next_io_flag && io_int_en;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_hold_above_1v0: assert property (
    (sup.above_hold && !sup.above_por) |=> rst_pin_oe && cpu_reset)
    else $error("reset pin not held above hold level");

  a_por_flags_clear: assert property (
    por_load |-> !core_int_flag && !io_int_flag && (thr == '0))
    else $error("power-on defaults not loaded");

  a_reset_thr_zero: assert property (
    $rose(por_load) |-> thr.core_supply_reset_threshold == 2'h0)
    else $error("reset threshold not zero after power-on");

  a_pwrup_release: assert property (
    (state == S_RUN && $past(state) == S_PWRUP) |-> $past(pwrup_done))
    else $error("released before power-up count ended");

  a_pwrup_holds: assert property (
    (state == S_PWRUP) |-> rst_pin_oe && cpu_reset)
    else $error("pin released during power-up count");

  a_start_vector: assert property (
    $fell(cpu_reset) |-> cpu_start && reset_vector == 16'h8000)
    else $error("start pulse or vector wrong at release");

  a_core_int_set: assert property (
    (state == S_RUN && sup.above_por && sup.above_reset &&
     !sup.core_above_int) |=> core_int_flag)
    else $error("core drop flag not set");

  a_bor_entry: assert property (
    (state == S_RUN && sup.above_por && !sup.above_reset)
      |=> state == S_BOR && bor_load && rst_pin_oe)
    else $error("supply drop reset not entered");

  a_bor_keeps_thr: assert property (
    bor_load |-> $stable(thr.core_supply_reset_threshold))
    else $error("reset threshold lost on supply drop reset");

  a_bor_hold: assert property (
    (state == S_BOR && !sup.above_reset)[*2] |-> rst_pin_oe && cpu_reset)
    else $error("reset released below reset threshold");

  a_bor_fast: assert property (
    (state == S_BOR && sup.above_por && sup.above_reset)
      |=> state == S_RUN && !rst_pin_oe)
    else $error("drop recovery not immediate");

  a_por_loss: assert property (
    !sup.above_por |=> (state == S_DEAD || state == S_POR_HOLD) &&
      thr == '0)
    else $error("power-on loss did not reset all");

  a_ext_reset: assert property (
    !rst_pin_in |=> cpu_reset)
    else $error("external pin low did not reset core");

  a_flag_sticky: assert property (
    (core_int_flag && !clr_core_int && state == S_RUN &&
     sup.above_reset && sup.above_por) |=> core_int_flag)
    else $error("core drop flag lost without clear");

  c_power_up: cover property (state == S_PWRUP ##1 state == S_RUN);
  c_bor_recover: cover property (state == S_BOR ##1 state == S_RUN);
  c_core_irq: cover property ($rose(supply_drop_interrupt_core));
  c_ext_reset: cover property (state == S_RUN && !rst_pin_in);

endmodule : pbs_supervisor

//--- pbs_pkg.sv
// constants, types and state codes for the supply supervisor sequencer
// assumes one 125 MHz system clock and analog comparators outside
package pbs_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int MCLK_FREQ_KHZ = 125000;
  localparam int RC_FREQ_KHZ = 7600;
  // typical power-up delay, in microseconds
  localparam int PWRUP_DELAY_US = 8600;
  // delay expressed in rc oscillator periods, rounded down
  localparam int PWRUP_RC_TICKS = PWRUP_DELAY_US * RC_FREQ_KHZ / 1000;
  // mclk cycles per rc period, rounded down, never below one
  localparam int RC_DIV_RAW = MCLK_FREQ_KHZ / RC_FREQ_KHZ;
  localparam int RC_DIV_CYCLES = (RC_DIV_RAW < 1) ? 1 : RC_DIV_RAW;

  // ------------------------------------------------------------------
  // supply levels seen by the comparators, in millivolts
  // ------------------------------------------------------------------
  localparam int CORE_HOLD_MV = 1000;
  localparam int CORE_POR_MV = 1200;

  // ------------------------------------------------------------------
  // threshold fields and reset values
  // ------------------------------------------------------------------
  localparam int THR_W = 2;
  localparam logic [THR_W-1:0] THR_POR_DEFAULT = 2'h0;
  localparam logic [THR_W-1:0] THR_BOR_DEFAULT = 2'h0;
  localparam logic [15:0] RESET_VECTOR = 16'h8000;

  // software-programmable threshold selections
  typedef struct packed {
    logic [THR_W-1:0] io_supply_int_threshold;
    logic [THR_W-1:0] core_supply_int_threshold;
    logic [THR_W-1:0] core_supply_reset_threshold;
  } pbs_thr_t;

  // comparator outputs, high while the supply is above the level
  typedef struct packed {
    logic above_hold;
    logic above_por;
    logic above_reset;
    logic core_above_int;
    logic io_above_int;
  } pbs_sup_t;

  // sequencer states
  typedef enum logic [2:0] {
    S_DEAD,
    S_POR_HOLD,
    S_WAIT_BOR,
    S_PWRUP,
    S_RUN,
    S_BOR
  } pbs_state_t;

endpackage : pbs_pkg

//--- pbs_pwrup_timer.sv
// power-up delay counter run from an rc-rate enable
// assumes run is held high for the whole delay; dropping it restarts
`timescale 1ns/1ns
module pbs_pwrup_timer
  import pbs_pkg::*;
#(
  parameter int RC_DIV = RC_DIV_CYCLES,
  parameter int TICKS = PWRUP_RC_TICKS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control and result
  input wire logic run,
  output logic done
);

  localparam int DCW = (RC_DIV > 1) ? $clog2(RC_DIV) : 1;
  localparam int CW = $clog2(TICKS + 1);

  logic [DCW-1:0] div;
  logic [CW-1:0] cnt;
  logic rc_tick;
  logic cnt_end;

  // ------------------------------------------------------------------
  // rc oscillator rate as a one-cycle enable
  // ------------------------------------------------------------------
  assign rc_tick = run && (div == DCW'(RC_DIV - 1));
  assign cnt_end = (cnt == CW'(TICKS));

  // divider restarts with the count so every delay is full length
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div <= '0;
    end else if (!run || rc_tick) begin
      div <= '0;
    end else begin
      div <= div + DCW'(1);
    end
  end

  // count rc periods, then hold done until run drops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      done <= 1'b0;
    end else if (!run) begin
      cnt <= '0;
      done <= 1'b0;
    end else if (rc_tick && !cnt_end) begin
      cnt <= cnt + CW'(1);
    end else if (cnt_end) begin
      done <= 1'b1;
    end
  end

endmodule : pbs_pwrup_timer

//--- pbs_pin_model.sv
// far side of the open-drain reset pin: pull-up and external driver
// assumes the device pulls low only while rst_pin_oe is high
`timescale 1ns/1ns
module pbs_pin_model (
  // device side
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  // external reset driver
  input wire logic ext_low,
  // resolved pin level
  output logic pin
);
  // wired-and of both pull-downs; the pull-up wins when nobody drives
  assign pin = ((rst_pin_oe && !rst_pin_out) || ext_low) ? 1'b0 : 1'b1;
endmodule : pbs_pin_model

//--- test_pbs_supervisor.sv
// self-checking bench for the supply supervisor sequencer
// assumes short power-up counts set through the parameters below
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
  n_errors++; $display("BAD %s expected %h seen %h", nm, exp, got); end end
module test_pbs_supervisor;
  import pbs_pkg::*;
  // --------------------------------------------------------------
  // set-up
  // --------------------------------------------------------------
  // short counts keep the run brief; the power-up delay bounds derive from them
  localparam int RDIV = 2;
  localparam int TICKS = 10;
  logic mclk, rst, thr_wr, clr_core_int, clr_io_int, ext_low;
  logic core_int_en, io_int_en, rst_pin_in, rst_pin_out, rst_pin_oe;
  logic cpu_reset, cpu_start, por_load, bor_load, irq_core, irq_io;
  logic core_int_flag, io_int_flag;
  logic [15:0] reset_vector;
  logic [7:0] r, pr;
  logic ef_c, ef_i;
  pbs_sup_t sup;
  pbs_thr_t thr_wdata, thr, tv;
  int n_errors, checks, seed, n;

  pbs_supervisor #(.RC_DIV(RDIV), .PWRUP_TICKS(TICKS)) dut_u (
    .mclk(mclk), .rst(rst), .sup(sup), .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .thr_wr(thr_wr),
    .thr_wdata(thr_wdata), .clr_core_int(clr_core_int),
    .clr_io_int(clr_io_int), .core_int_en(core_int_en),
    .io_int_en(io_int_en), .thr(thr), .cpu_reset(cpu_reset),
    .cpu_start(cpu_start), .reset_vector(reset_vector),
    .por_load(por_load), .bor_load(bor_load),
    .core_int_flag(core_int_flag), .io_int_flag(io_int_flag),
    .supply_drop_interrupt_core(irq_core),
    .supply_drop_interrupt_io(irq_io));

  pbs_pin_model pin_u (.rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .ext_low(ext_low), .pin(rst_pin_in));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // clock at 125 mhz
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // let one sampling edge pass, then look at settled outputs
  task nxt;
    @(posedge mclk);
    @(negedge mclk);
  endtask : nxt

  // count cycles until the start pulse, bounded so a hang shows up
  task wait_start(input int lim, output int cnt);
    cnt = 0;
    while (cpu_start !== 1'b1 && cnt < lim) begin
      @(negedge mclk);
      cnt++;
    end
  endtask : wait_start

  // sticky flag: set by a low level, else kept unless cleared
  function automatic logic exp_flag(input logic above, input logic clr,
                                    input logic prev);
    exp_flag = !above | (prev & !clr);
  endfunction : exp_flag

  // full power-up walk from a dead core supply
  task pwr_up;
    @(posedge mclk);
    sup.above_hold <= 1'b1;
    nxt;
    `CHK("hold pin", 1'b1, rst_pin_oe)
    @(posedge mclk);
    sup.above_por <= 1'b1;
    nxt;
    `CHK("por load", 1'b1, por_load)
    `CHK("por thr", 6'h00, thr)
    @(posedge mclk);
    sup.above_reset <= 1'b1;
    sup.core_above_int <= 1'b1;
    sup.io_above_int <= 1'b1;
    nxt;
    `CHK("held in delay", 1'b1, rst_pin_oe)
    wait_start(RDIV * (TICKS + 1) + 8, n);
    `CHK("delay long", 1'b1, n >= RDIV * TICKS - 1)
    `CHK("delay short", 1'b1, n <= RDIV * (TICKS + 1) + 4)
    `CHK("vector", 16'h8000, reset_vector)
    `CHK("pin free", 1'b0, rst_pin_oe)
    `CHK("cpu run", 1'b0, cpu_reset)
    nxt;
    `CHK("start pulse", 1'b0, cpu_start)
  endtask : pwr_up

  task close_out;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // hang guard, well beyond the expected run length
  initial begin
    #(8 * 4000);
    n_errors++;
    close_out;
  end

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    seed = 32'hbc7e;
    n_errors = 0;
    checks = 0;
    rst = 1'b1;
    sup = '0;
    thr_wr = 1'b0;
    thr_wdata = '0;
    clr_core_int = 1'b0;
    clr_io_int = 1'b0;
    core_int_en = 1'b0;
    io_int_en = 1'b0;
    ext_low = 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    `CHK("rst cpu", 1'b1, cpu_reset)
    `CHK("rst thr", 6'h00, thr)
    @(posedge mclk);
    rst <= 1'b0;
    pwr_up;
    // random threshold writes, then a known value with a high field
    for (int i = 0; i < 9; i++) begin
      tv = (i == 8) ? 6'h3b : 6'($random(seed));
      @(posedge mclk);
      thr_wr <= 1'b1;
      thr_wdata <= tv;
      @(posedge mclk);
      thr_wr <= 1'b0;
      @(negedge mclk);
      `CHK("thr write", tv, thr)
    end
    // random drops, clears and enables; set wins over clear
    pr = 8'h0f;
    ef_c = 1'b0;
    ef_i = 1'b0;
    for (int i = 0; i < 40; i++) begin
      r = 8'($random(seed));
      @(posedge mclk);
      sup.core_above_int <= r[0] | r[1];
      sup.io_above_int <= r[2] | r[3];
      clr_core_int <= r[4];
      clr_io_int <= r[5];
      core_int_en <= r[6];
      io_int_en <= r[7];
      @(negedge mclk);
      ef_c = exp_flag(pr[0] | pr[1], pr[4], ef_c);
      ef_i = exp_flag(pr[2] | pr[3], pr[5], ef_i);
      `CHK("core flag", ef_c, core_int_flag)
      `CHK("io flag", ef_i, io_int_flag)
      `CHK("core irq", ef_c & pr[6], irq_core)
      `CHK("io irq", ef_i & pr[7], irq_io)
      pr = r;
    end
    @(posedge mclk);
    sup.core_above_int <= 1'b1;
    sup.io_above_int <= 1'b1;
    // core supply drops below the reset threshold
    @(posedge mclk);
    sup.above_reset <= 1'b0;
    nxt;
    `CHK("drop pin", 1'b1, rst_pin_oe)
    `CHK("drop level", 1'b0, rst_pin_out)
    `CHK("drop sensed", 1'b0, rst_pin_in)
    `CHK("drop cpu", 1'b1, cpu_reset)
    `CHK("drop load", 1'b1, bor_load)
    `CHK("kept thr", 2'h3, thr.core_supply_reset_threshold)
    `CHK("drop thr", 6'h03, thr)
    for (int i = 0; i < 6; i++) begin
      nxt;
      `CHK("stay low", 1'b1, rst_pin_oe)
    end
    @(posedge mclk);
    sup.above_reset <= 1'b1;
    wait_start(6, n);
    `CHK("quick release", 1'b1, n <= 3)
    `CHK("release pin", 1'b0, rst_pin_oe)
    // an outside party pulls the pin low
    @(posedge mclk);
    ext_low <= 1'b1;
    nxt;
    `CHK("ext hold", 1'b1, cpu_reset)
    @(posedge mclk);
    ext_low <= 1'b0;
    wait_start(6, n);
    `CHK("ext release", 1'b1, n <= 3)
    // loss below the power-on level needs the full sequence again
    @(posedge mclk);
    sup.above_por <= 1'b0;
    sup.above_reset <= 1'b0;
    nxt;
    `CHK("lost thr", 6'h00, thr)
    `CHK("lost cpu", 1'b1, cpu_reset)
    pwr_up;
    `CHK("full delay", 1'b1, n >= RDIV * TICKS - 1)
    close_out;
  end
endmodule : test_pbs_supervisor
